/* logic/sst_pkg.sv */
// constants and types for the sensor-interface safety self-test block
// Operation
// - start test only with both channels off
// - ignore channel-on and regulator-off while running
// - only stop bit aborts; master abort flags it
// - running flag during test, done flag after
// - results clear on read or on any start while idle
// - ground-short bits hold master results
// - slave mode pulls down both channels
// - slave pass when undervoltage flag clear
// - master checks battery short, excludes channel
// - discharge after each check, then channel two
// - phase one drives channel one only
// - phase two mirrors phase one
// - never both channels on together while running
// - master ends itself; slave abort unflagged
// - buffer must hold empty code after read
// - test bit keeps old data after read
// - test level drives selected output statically
// - select code picks output one or two
// - one output in test mode at most
// - stored slot identifier returned with data
// - diagnostic bit on undervoltage or parity
// - data and identifier stored in one access
// - forced failures only in self-test mode; buffer test bit acts in any mode
package sst_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int T_LONG_US = 512;
  localparam int T_SHORT_US = 128;
  localparam int LONG_CYC = T_LONG_US * (CLK_HZ / 1_000_000);
  localparam int SHORT_CYC = T_SHORT_US * (CLK_HZ / 1_000_000);
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STS = 8'h04;
  localparam logic [7:0] ADDR_SELF_TEST_SAFETY_REG = 8'h08;
  localparam logic [7:0] ADDR_XST = 8'h0C;
  localparam logic [7:0] ADDR_ST2 = 8'h10;
  localparam logic [7:0] ADDR_SIDB = 8'h40;
  localparam logic [7:0] ADDR_DATB = 8'h80;
  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int CTRL_W = 5;
  localparam int CTRL_ON1 = 0;
  localparam int CTRL_ON2 = 1;
  localparam int CTRL_REG = 2;
  localparam int CTRL_STM = 3;
  localparam int CTRL_SIDEN = 4;
  localparam int STS_START = 0;
  localparam int STS_MASTER = 1;
  localparam int STS_STOP = 2;
  localparam int STS_SEL_LO = 5;
  localparam int STS_LVL = 10;
  localparam int SEL_W = 5;
  localparam logic [SEL_W-1:0] SEL_OUT1 = 5'h15;
  localparam logic [SEL_W-1:0] SEL_OUT2 = 5'h16;
  localparam int SELF_TEST_SAFETY_REG_W = 3;
  localparam int SELF_TEST_SAFETY_REG_BET = 0;
  localparam int SELF_TEST_SAFETY_REG_FCRC = 1;
  localparam int SELF_TEST_SAFETY_REG_FSID = 2;
  localparam int XST_RUN = 0;
  localparam int XST_DONE = 1;
  localparam int XST_ABT = 2;
  localparam int XST_RES = 3;
  localparam int XST_STB = 5;
  localparam int XST_STG = 7;
  localparam int ST2_STG1 = 0;
  localparam int ST2_BE1 = 1;
  localparam int ST2_UV1 = 2;
  localparam int ST2_STG2 = 8;
  localparam int ST2_BE2 = 9;
  localparam int ST2_UV2 = 10;
  localparam int DATA_W = 10;
  localparam int SID_W = 5;
  localparam int FR_SID_LO = 10;
  localparam int FR_DIAG = 15;
  localparam logic [DATA_W-1:0] EMPTY_CODE = 10'h1F0;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SST_IDLE = 3'h0, SST_SL_PD = 3'h1, SST_MS_ON = 3'h2, SST_MS_PD = 3'h3,
    SST_MP1_ON = 3'h4, SST_MP1_PD = 3'h5, SST_MP2_ON = 3'h6, SST_MP2_PD = 3'h7
  } sst_state_t;
endpackage : sst_pkg

/* logic/sst_links.sv */
// interfaces between the top and its interval timer and output driver
`timescale 1ns/1ps
interface sst_tmr_if;
  logic start;
  logic longSel;
  logic cancel;
  logic done;
  modport ctl(output start, longSel, cancel, input done);
  modport timer(input start, longSel, cancel, output done);
endinterface : sst_tmr_if

interface sst_dout_if;
  import sst_pkg::*;
  logic [SEL_W-1:0] sel;
  logic lvl;
  logic norm1;
  logic norm2;
  logic out1;
  logic out2;
  modport ctl(output sel, lvl, norm1, norm2, input out1, out2);
  modport drv(input sel, lvl, norm1, norm2, output out1, out2);
endinterface : sst_dout_if

/* logic/sst_timer.sv */
// interval timer for the discharge and settle intervals
`timescale 1ns/1ps
module sst_timer #(
  parameter int LONG_CYC = sst_pkg::LONG_CYC,
  parameter int SHORT_CYC = sst_pkg::SHORT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  sst_tmr_if.timer t
);
  import sst_pkg::*;
  localparam int CW = $clog2(LONG_CYC + 1);
  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad
    $error("timer lengths unusable");
  end
  typedef struct packed {
    logic act;
    logic [CW-1:0] cnt;
    logic done;
  } sst_tmr_st_t;
  sst_tmr_st_t r;
  sst_tmr_st_t n;
  // --------------------------------------------------------------
  // countdown
  // --------------------------------------------------------------
  // load on start, pulse done when the count runs out
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    if (t.cancel)
    begin
      n.act = 1'b0;
    end
    else if (t.start)
    begin
      n.act = 1'b1;
      n.cnt = t.longSel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
    end
    else if (r.act)
    begin
      if (r.cnt == '0)
      begin
        n.act = 1'b0;
        n.done = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt - 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end
  assign t.done = r.done;
endmodule : sst_timer

/* logic/sst_dout.sv */
// data output driver with static test-pattern mode
`timescale 1ns/1ps
module sst_dout (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selection and outputs
  sst_dout_if.drv d
);
  import sst_pkg::*;
  typedef struct packed {
    logic out1;
    logic out2;
  } sst_dout_st_t;
  sst_dout_st_t r;
  sst_dout_st_t n;
  // --------------------------------------------------------------
  // output select
  // --------------------------------------------------------------
  // a single select code can name one output only
  always_comb
  begin
    n.out1 = (d.sel == SEL_OUT1) ? d.lvl : d.norm1;
    n.out2 = (d.sel == SEL_OUT2) ? d.lvl : d.norm2;
  end
  // output flops
  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end
  assign d.out1 = r.out1;
  assign d.out2 = r.out2;
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_lvl1;
    @(posedge clk) disable iff (rst)
    d.sel == SEL_OUT1 |=> d.out1 == $past(d.lvl) && d.out2 == $past(d.norm2);
  endproperty
  a_lvl1: assert property (p_lvl1) else $error("output one test level wrong");
  property p_off;
    @(posedge clk) disable iff (rst)
    d.sel != SEL_OUT1 && d.sel != SEL_OUT2 |=>
      d.out1 == $past(d.norm1) && d.out2 == $past(d.norm2);
  endproperty
  a_off: assert property (p_off) else $error("test mode not disabled");
  property p_one;
    @(posedge clk) disable iff (rst)
    d.sel == SEL_OUT2 |=> d.out1 == $past(d.norm1) && d.out2 == $past(d.lvl);
  endproperty
  a_one: assert property (p_one) else $error("two outputs in test mode");
endmodule : sst_dout

/* logic/sst_top.sv */
// self-test block: test sequencer, buffer check, tagging, bus slave
`timescale 1ns/1ps
module sst_top #(
  parameter int NSLOT = 4,
  parameter int LONG_CYC = sst_pkg::LONG_CYC,
  parameter int SHORT_CYC = sst_pkg::SHORT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // line monitors
  input wire logic chan1Undervolt,
  input wire logic chan2Undervolt,
  input wire logic chan1BatteryShort,
  input wire logic chan2BatteryShort,
  input wire logic chan1GroundShort,
  input wire logic chan2GroundShort,
  input wire logic supplyUndervolt,
  input wire logic parityFault,
  // decoded sensor frames
  input wire logic frameValid,
  input wire logic frameChan,
  input wire logic [$clog2(NSLOT)-1:0] frameSlot,
  input wire logic [sst_pkg::DATA_W-1:0] frameData,
  input wire logic dataIn1,
  input wire logic dataIn2,
  // line and test controls
  output logic chan1SupplyOn,
  output logic chan2SupplyOn,
  output logic chan1Pulldown,
  output logic chan2Pulldown,
  output logic shortDetectMask,
  output logic supplyRailOn,
  output logic forceChecksumFail,
  output logic dataOut1,
  output logic dataOut2
);
  import sst_pkg::*;
  localparam int NB = 2 * NSLOT;
  localparam int IW = $clog2(NB);
  if (NSLOT < 2 || NSLOT > 8) begin : g_bad
    $error("NSLOT must be 2 to 8");
  end
  typedef struct packed {
    sst_state_t state;
    logic chIdx;
    logic master;
    logic running;
    logic done;
    logic aborted;
    logic hold;
    logic [1:0] res;
    logic [1:0] stb;
    logic [1:0] stg;
    logic [1:0] excl;
    logic [1:0] be;
    logic [CTRL_W-1:0] ctrl;
    logic [SEL_W-1:0] sel;
    logic lvl;
    logic [SELF_TEST_SAFETY_REG_W-1:0] self_test_safety_reg;
    logic pendV;
    logic [IW-1:0] pendIdx;
    logic [NB-1:0][DATA_W-1:0] bufD;
    logic [NB-1:0][SID_W-1:0] bufS;
    logic [NB-1:0][SID_W-1:0] sidT;
    logic aV;
    logic [7:0] aAddr;
    logic rdP;
    logic [7:0] rdAddr;
    logic hready;
    logic [31:0] hrdata;
    logic on1, on2, pd1, pd2, mask, regOn, fcrc;
    logic tStart, tLong, tCancel;
  } sst_top_st_t;
  sst_top_st_t r;
  sst_top_st_t n;
  logic stopWr;
  sst_tmr_if tIf();
  sst_dout_if dIf();
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // word-aligned hit inside a per-slot register bank
  function automatic logic inBank(input logic [7:0] a, input logic [7:0] base);
    inBank = a[1:0] == 2'h0 && a >= base && a < base + 8'(4 * NB);
  endfunction : inBank
  // slot index of a bank address
  function automatic logic [IW-1:0] bankIdx(input logic [7:0] a,
                                             input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    bankIdx = off[2 +: IW];
  endfunction : bankIdx
  // stop bit written while a test runs
  assign stopWr = r.aV && r.aAddr == ADDR_STS && hwdata[STS_STOP] && r.running;
  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  // bus, register effects, sequencer and buffer check in priority order
  always_comb
  begin
    logic [31:0] rd;
    logic [IW-1:0] ri;
    logic [IW-1:0] fi;
    logic fin;
    rd = 32'h0;
    ri = bankIdx(r.rdAddr, ADDR_DATB);
    fi = IW'(32'(frameChan) * NSLOT + 32'(frameSlot));
    fin = 1'b0;
    n = r;
    n.tStart = 1'b0;
    n.tCancel = 1'b0;
    n.pendV = 1'b0;
    // read data mux
    if (r.rdAddr == ADDR_CTRL)
      rd[CTRL_W-1:0] = r.ctrl;
    else if (r.rdAddr == ADDR_STS)
    begin
      rd[STS_SEL_LO +: SEL_W] = r.sel;
      rd[STS_LVL] = r.lvl;
      rd[STS_MASTER] = r.master;
    end
    else if (r.rdAddr == ADDR_SELF_TEST_SAFETY_REG)
      rd[SELF_TEST_SAFETY_REG_W-1:0] = r.self_test_safety_reg;
    else if (r.rdAddr == ADDR_XST)
    begin
      rd[XST_RUN] = r.running;
      rd[XST_DONE] = r.done;
      rd[XST_ABT] = r.aborted;
      rd[XST_RES +: 2] = r.res;
      rd[XST_STB +: 2] = r.stb;
      rd[XST_STG +: 2] = r.stg;
    end
    else if (r.rdAddr == ADDR_ST2)
    begin
      rd[ST2_STG1] = r.hold ? r.stg[0] : chan1GroundShort;
      rd[ST2_STG2] = r.hold ? r.stg[1] : chan2GroundShort;
      rd[ST2_BE1] = r.be[0];
      rd[ST2_BE2] = r.be[1];
      rd[ST2_UV1] = chan1Undervolt;
      rd[ST2_UV2] = chan2Undervolt;
    end
    else if (inBank(r.rdAddr, ADDR_SIDB))
      rd[SID_W-1:0] = r.sidT[bankIdx(r.rdAddr, ADDR_SIDB)];
    else if (inBank(r.rdAddr, ADDR_DATB))
    begin
      rd[DATA_W-1:0] = r.bufD[ri];
      if (r.ctrl[CTRL_SIDEN])
      begin
        // forced mismatch inverts the returned identifier
        rd[FR_SID_LO +: SID_W] = r.bufS[ri] ^
          {SID_W{r.ctrl[CTRL_STM] & r.self_test_safety_reg[SELF_TEST_SAFETY_REG_FSID]}};
        rd[FR_DIAG] = supplyUndervolt | parityFault;
      end
    end
    // read data phase: answer and read side effects
    if (r.rdP)
    begin
      n.rdP = 1'b0;
      n.hready = 1'b1;
      n.hrdata = rd;
      if (r.rdAddr == ADDR_XST)
      begin
        n.done = 1'b0;
        n.aborted = 1'b0;
        n.res = 2'h0;
        n.stb = 2'h0;
        n.stg = 2'h0;
        n.hold = 1'b0;
      end
      if (r.rdAddr == ADDR_ST2)
        n.be = 2'h0;
      if (inBank(r.rdAddr, ADDR_DATB))
      begin
        if (!r.self_test_safety_reg[SELF_TEST_SAFETY_REG_BET])
          n.bufD[ri] = EMPTY_CODE;
        n.pendV = 1'b1;
        n.pendIdx = ri;
      end
    end
    // address phase capture; reads take one wait state
    n.aV = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      n.aV = hwrite;
      n.aAddr = haddr[7:0];
      if (!hwrite)
      begin
        n.rdP = 1'b1;
        n.hready = 1'b0;
        n.rdAddr = haddr[7:0];
      end
    end
    // write data phase
    if (r.aV)
    begin
      if (r.aAddr == ADDR_CTRL)
      begin
        n.ctrl = hwdata[CTRL_W-1:0];
        if (r.running)
        begin
          n.ctrl[CTRL_ON1] = r.ctrl[CTRL_ON1];
          n.ctrl[CTRL_ON2] = r.ctrl[CTRL_ON2];
          n.ctrl[CTRL_REG] = r.ctrl[CTRL_REG] | hwdata[CTRL_REG];
        end
      end
      else if (r.aAddr == ADDR_STS)
      begin
        n.sel = hwdata[STS_SEL_LO +: SEL_W];
        n.lvl = hwdata[STS_LVL];
        if (stopWr)
        begin
          n.state = SST_IDLE;
          n.running = 1'b0;
          n.aborted = r.master;
          n.tCancel = 1'b1;
        end
        else if (hwdata[STS_START] && !r.running)
        begin
          n.done = 1'b0;
          n.aborted = 1'b0;
          n.res = 2'h0;
          n.stb = 2'h0;
          n.stg = 2'h0;
          n.hold = 1'b0;
          if (!r.on1 && !r.on2)
          begin
            n.running = 1'b1;
            n.master = hwdata[STS_MASTER];
            n.state = hwdata[STS_MASTER] ? SST_MS_ON : SST_SL_PD;
            n.chIdx = 1'b0;
            n.excl = 2'h0;
            n.tStart = 1'b1;
            n.tLong = 1'b1;
          end
        end
      end
      else if (r.aAddr == ADDR_SELF_TEST_SAFETY_REG)
        n.self_test_safety_reg = hwdata[SELF_TEST_SAFETY_REG_W-1:0];
      else if (inBank(r.aAddr, ADDR_SIDB))
        n.sidT[bankIdx(r.aAddr, ADDR_SIDB)] = hwdata[SID_W-1:0];
    end
    // sequencer steps at the end of each timed interval
    if (n.running && tIf.done)
    begin
      n.tStart = 1'b1;
      n.tLong = 1'b0;
      unique case (r.state)
        SST_IDLE:
          n.tStart = 1'b0;
        SST_SL_PD:
        begin
          n.res[0] = !chan1Undervolt;
          n.res[1] = !chan2Undervolt;
          fin = 1'b1;
        end
        SST_MS_ON:
        begin
          if (r.chIdx ? chan2BatteryShort : chan1BatteryShort)
          begin
            n.stb[r.chIdx] = 1'b1;
            n.excl[r.chIdx] = 1'b1;
          end
          n.state = SST_MS_PD;
        end
        SST_MS_PD:
        begin
          n.tLong = 1'b1;
          if (!r.chIdx)
          begin
            n.chIdx = 1'b1;
            n.state = SST_MS_ON;
          end
          else if (!r.excl[0])
            n.state = SST_MP1_ON;
          else if (!r.excl[1])
            n.state = SST_MP2_ON;
          else
            fin = 1'b1;
        end
        SST_MP1_ON:
        begin
          if (chan1Undervolt)
            n.stg[0] = 1'b1;
          if (!chan2Undervolt)
            n.res[1] = 1'b1;
          n.state = SST_MP1_PD;
        end
        SST_MP1_PD:
        begin
          n.tLong = 1'b1;
          if (!r.excl[1])
            n.state = SST_MP2_ON;
          else
            fin = 1'b1;
        end
        SST_MP2_ON:
        begin
          if (chan2Undervolt)
            n.stg[1] = 1'b1;
          if (!chan1Undervolt)
            n.res[0] = 1'b1;
          n.state = SST_MP2_PD;
        end
        SST_MP2_PD:
          fin = 1'b1;
      endcase
      if (fin)
      begin
        n.tStart = 1'b0;
        n.state = SST_IDLE;
        n.running = 1'b0;
        n.done = 1'b1;
        n.hold = r.master;
      end
    end
    // buffer check one cycle after a data read; set wins over clear
    if (r.pendV && r.bufD[r.pendIdx] != EMPTY_CODE)
      n.be[r.pendIdx >= IW'(NSLOT)] = 1'b1;
    // decoded frame stored with its slot identifier
    if (frameValid)
    begin
      n.bufD[fi] = frameData;
      n.bufS[fi] = r.sidT[fi];
    end
    // line controls follow the sequencer while running
    n.on1 = n.running ? (n.state == SST_MS_ON && !n.chIdx) || n.state == SST_MP1_ON
                      : n.ctrl[CTRL_ON1];
    n.on2 = n.running ? (n.state == SST_MS_ON && n.chIdx) || n.state == SST_MP2_ON
                      : n.ctrl[CTRL_ON2];
    n.pd1 = n.running && (n.state == SST_SL_PD || n.state == SST_MP1_PD ||
                          (n.state == SST_MS_PD && !n.chIdx));
    n.pd2 = n.running && (n.state == SST_SL_PD || n.state == SST_MP2_PD ||
                          (n.state == SST_MS_PD && n.chIdx));
    n.mask = n.running && (n.state == SST_MS_ON || n.state == SST_MP1_ON ||
                           n.state == SST_MP2_ON);
    n.regOn = n.ctrl[CTRL_REG];
    n.fcrc = n.ctrl[CTRL_STM] & n.self_test_safety_reg[SELF_TEST_SAFETY_REG_FCRC];
  end
  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.hready <= 1'b1;
      r.bufD <= {NB{EMPTY_CODE}};
    end
    else
      r <= n;
  end
  // --------------------------------------------------------------
  // submodules and outputs
  // --------------------------------------------------------------
  assign tIf.start = r.tStart;
  assign tIf.longSel = r.tLong;
  assign tIf.cancel = r.tCancel;
  assign dIf.sel = r.sel;
  assign dIf.lvl = r.lvl;
  assign dIf.norm1 = dataIn1;
  assign dIf.norm2 = dataIn2;
  sst_timer #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) uTimer (
    .clk(clk), .rst(rst), .t(tIf.timer));
  sst_dout uDout (.clk(clk), .rst(rst), .d(dIf.drv));
  assign hreadyout = r.hready;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign chan1SupplyOn = r.on1;
  assign chan2SupplyOn = r.on2;
  assign chan1Pulldown = r.pd1;
  assign chan2Pulldown = r.pd2;
  assign shortDetectMask = r.mask;
  assign supplyRailOn = r.regOn;
  assign forceChecksumFail = r.fcrc;
  assign dataOut1 = dIf.out1;
  assign dataOut2 = dIf.out2;
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_startOff;
    $rose(r.running) |-> !$past(r.on1) && !$past(r.on2);
  endproperty
  a_startOff: assert property (p_startOff) else $error("test began with line on");
  property p_ctrlHold;
    r.running && r.aV && r.aAddr == ADDR_CTRL |=> $stable(r.ctrl[CTRL_ON2:CTRL_ON1]);
  endproperty
  a_ctrlHold: assert property (p_ctrlHold) else $error("channel switched on in test");
  property p_abort;
    stopWr && r.master |=> r.aborted && !r.running && !r.on1 && !r.on2;
  endproperty
  a_abort: assert property (p_abort) else $error("master abort not flagged");
  property p_finish;
    r.running && tIf.done && !stopWr && r.state == SST_MP2_PD |=> r.done && !r.running;
  endproperty
  a_finish: assert property (p_finish) else $error("done flag missing");
  property p_clrRead;
    r.rdP && r.rdAddr == ADDR_XST && !r.running |=> !r.done && r.stb == 2'h0 && !r.hold;
  endproperty
  a_clrRead: assert property (p_clrRead) else $error("results kept after read");
  property p_slave;
    r.state == SST_SL_PD && tIf.done && !stopWr |=>
      r.res == ~$past({chan2Undervolt, chan1Undervolt}) && !r.pd1 && !r.pd2;
  endproperty
  a_slave: assert property (p_slave) else $error("slave result wrong");
  property p_noBoth;
    r.running |-> !(r.on1 && r.on2);
  endproperty
  a_noBoth: assert property (p_noBoth) else $error("both channels on");
  property p_beFault;
    r.pendV && r.bufD[r.pendIdx] != EMPTY_CODE |=> r.be != 2'h0;
  endproperty
  a_beFault: assert property (p_beFault) else $error("buffer fault missed");
  property p_rst;
    disable iff (1'b0) rst |=> r.state == SST_IDLE && !r.running && !r.done;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left test active");
  c_master: cover property (r.master && $fell(r.running) && !stopWr);
  c_slaveAbort: cover property (stopWr && !r.master);
  c_beFault: cover property ($rose(r.be[0]));
  c_exclude: cover property (r.excl == 2'h3);
endmodule : sst_top

/* testbench/sst_line_model.sv */
// sensor line model answering the supply controls
`timescale 1ns/1ps
module sst_line_model (
  // line controls
  input wire logic chan1SupplyOn,
  input wire logic chan2SupplyOn,
  input wire logic coupled,
  // monitor flags
  output logic chan1Undervolt,
  output logic chan2Undervolt
);
  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  // a line sags unless its own supply, or a coupled neighbour, lifts it
  assign chan1Undervolt = !(chan1SupplyOn || (coupled && chan2SupplyOn));
  assign chan2Undervolt = !(chan2SupplyOn || (coupled && chan1SupplyOn));
endmodule : sst_line_model

/* testbench/sst_top_tb.sv */
// self-checking bench for the self-test block
`timescale 1ns/1ps
module sst_top_tb;
  import sst_pkg::*;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h1, hwrite = 1'h0, frameValid = 1'h0;
  logic coupled = 1'h0, dataIn1 = 1'h0, dataIn2 = 1'h0, supplyUndervolt = 1'h0;
  logic frameChan = 1'h0, hready, hreadyout, c1Uv, c2Uv, c1On, c2On, dataOut1, dataOut2;
  logic [1:0] htrans = 2'h0, frameSlot = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [DATA_W-1:0] frameData = 10'h0;
  logic stb1 = 1'h0, gs1 = 1'h0, pFault = 1'h0, fcf;
  int errCount = 0, testsRun = 0;
  // ----------------------------------------------------------------
  // clock, design and line model
  // ----------------------------------------------------------------
  always #25 clk = ~clk;
  assign hready = hreadyout;
  sst_top #(.LONG_CYC(20), .SHORT_CYC(5)) dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .chan1Undervolt(c1Uv), .chan2Undervolt(c2Uv), .chan1BatteryShort(stb1),
    .chan2BatteryShort(1'h0), .chan1GroundShort(gs1), .chan2GroundShort(1'h0),
    .supplyUndervolt(supplyUndervolt), .parityFault(pFault), .frameValid(frameValid),
    .frameChan(frameChan), .frameSlot(frameSlot), .frameData(frameData),
    .dataIn1(dataIn1), .dataIn2(dataIn2), .chan1SupplyOn(c1On), .chan2SupplyOn(c2On),
    .chan1Pulldown(), .chan2Pulldown(), .shortDetectMask(), .supplyRailOn(),
    .forceChecksumFail(fcf), .dataOut1(dataOut1), .dataOut2(dataOut2));
  sst_line_model lines (.chan1SupplyOn(c1On), .chan2SupplyOn(c2On), .coupled(coupled),
    .chan1Undervolt(c1Uv), .chan2Undervolt(c2Uv));
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  // single word transfer; address held until taken, data until answered
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e)
    begin
      errCount++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd
  // one decoded frame into channel one, slot zero
  task automatic frame(input logic [DATA_W-1:0] d);
    frameData <= d;
    frameValid <= 1'h1;
    @(posedge clk);
    frameValid <= 1'h0;
  endtask : frame
  task stop_test;
    $display("checks %0d errors %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // monitors and watchdog
  // ----------------------------------------------------------------
  // both supplies must never be on together
  always @(posedge clk)
    if (!rst && c1On === 1'h1 && c2On === 1'h1) chk("supplies", 32'h0, 32'h3);
  initial
  begin
    repeat (6000) @(posedge clk);
    errCount++;
    stop_test;
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(ADDR_XST, 32'h0);
    bus(1'h1, ADDR_STS, 32'h1);
    repeat (300) @(posedge clk);
    rd(ADDR_XST, 32'h2);
    bus(1'h1, ADDR_STS, 32'h1);
    repeat (300) @(posedge clk);
    bus(1'h1, ADDR_CTRL, 32'h1);
    bus(1'h1, ADDR_STS, 32'h1);
    rd(ADDR_XST, 32'h0);
    bus(1'h1, ADDR_CTRL, 32'h0);
    coupled <= 1'h1;
    bus(1'h1, ADDR_STS, 32'h3);
    repeat (300) @(posedge clk);
    rd(ADDR_XST, 32'h1A);
    rd(ADDR_XST, 32'h0);
    coupled <= 1'h0;
    // channel one shorted to battery: excluded, ground-short bits held
    stb1 <= 1'h1;
    gs1 <= 1'h1;
    bus(1'h1, ADDR_STS, 32'h3);
    repeat (300) @(posedge clk);
    rd(ADDR_ST2, 32'h404);
    rd(ADDR_XST, 32'h22);
    rd(ADDR_ST2, 32'h405);
    stb1 <= 1'h0;
    gs1 <= 1'h0;
    bus(1'h1, ADDR_STS, 32'h3);
    repeat (30) @(posedge clk);
    rd(ADDR_XST, 32'h1);
    bus(1'h1, ADDR_CTRL, 32'h3);
    chk("supply on", 32'h0, {31'h0, c1On});
    bus(1'h1, ADDR_STS, 32'h4);
    rd(ADDR_XST, 32'h4);
    rd(ADDR_CTRL, 32'h0);
    bus(1'h1, ADDR_CTRL, 32'h0);
    bus(1'h1, ADDR_STS, 32'h1);
    bus(1'h1, ADDR_STS, 32'h4);
    rd(ADDR_XST, 32'h0);
    bus(1'h1, ADDR_STS, 32'h6A0);
    repeat (3) @(posedge clk);
    chk("outputs", 32'h2, {30'h0, dataOut1, dataOut2});
    dataIn1 <= 1'h1;
    dataIn2 <= 1'h1;
    bus(1'h1, ADDR_STS, 32'h2C0);
    repeat (3) @(posedge clk);
    chk("outputs", 32'h2, {30'h0, dataOut1, dataOut2});
    bus(1'h1, ADDR_SIDB, 32'hB);
    bus(1'h1, ADDR_CTRL, 32'h10);
    frame(10'h55);
    rd(ADDR_DATB, 32'h2C55);
    rd(ADDR_ST2, 32'h404);
    bus(1'h1, ADDR_SELF_TEST_SAFETY_REG, 32'h1);
    frame(10'h55);
    rd(ADDR_DATB, 32'h2C55);
    repeat (3) @(posedge clk);
    rd(ADDR_ST2, 32'h406);
    rd(ADDR_ST2, 32'h404);
    supplyUndervolt <= 1'h1;
    rd(ADDR_DATB, 32'hAC55);
    // parity fault alone, then forced failures outside and inside self-test mode
    supplyUndervolt <= 1'h0;
    pFault <= 1'h1;
    bus(1'h1, ADDR_SELF_TEST_SAFETY_REG, 32'h7);
    rd(ADDR_DATB, 32'hAC55);
    chk("checksum force", 32'h0, {31'h0, fcf});
    bus(1'h1, ADDR_CTRL, 32'h18);
    rd(ADDR_DATB, 32'hD055);
    chk("checksum force", 32'h1, {31'h0, fcf});
    stop_test;
  end
endmodule : sst_top_tb
